// ### inc/civsr_pkg.sv
`default_nettype none
package civsr_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LEFT_INPUT_AMP_ROUTE = 8'h25;
    localparam logic [7:0] IDX_RIGHT_INPUT_AMP_ROUTE = 8'h26;
    localparam logic [7:0] IDX_LEFT_SPEAKER_VOLUME = 8'h28;
    localparam logic [7:0] IDX_RIGHT_SPEAKER_VOLUME = 8'h29;
    localparam logic [7:0] IDX_THERMAL_FLAGS = 8'h2f;
    localparam logic [7:0] IDX_MIC_BIAS_CTRL = 8'h30;
    localparam int ADDR_W = 10;
    // input amp fields
    localparam int AMP_ON_BIT = 4;
    localparam logic [3:0] ROUTE_RST = 4'h8;
    // speaker volume fields
    localparam int COMMIT_BIT = 8;
    localparam int ZC_BIT = 7;
    localparam logic [6:0] GAIN_RST = 7'h00;
    localparam logic [6:0] GAIN_MUTE_TOP = 7'h2f;
    localparam logic [6:0] GAIN_MIN_TOP = 7'h35;
    localparam logic [6:0] GAIN_ZERO_DB = 7'h79;
    localparam logic signed [7:0] GAIN_MIN_DB = -8'sd68;
    // thermal flag positions
    localparam int HP_FAULT_BIT = 3;
    localparam int HP_WARN_BIT = 2;
    localparam int SPK_FAULT_BIT = 1;
    localparam int SPK_WARN_BIT = 0;
    // mic bias / sensor control fields
    localparam int RSVD_HI_BIT = 15;
    localparam int CUR_LIM_LSB = 12;
    localparam int SHORT_LIM_LSB = 10;
    localparam int SENSE_ON_BIT = 9;
    localparam int CUR_FLAG_BIT = 7;
    localparam int SHORT_FLAG_BIT = 6;
    localparam int RSVD_LO_BIT = 5;
    localparam int HP_SENSOR_BIT = 2;
    localparam int SPK_SENSOR_BIT = 1;
    localparam int MIC_LVL_BIT = 0;
    localparam logic [2:0] CUR_LIM_RST = 3'h0;
    localparam logic [1:0] SHORT_LIM_RST = 2'h0;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } civsr_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } civsr_apb_rsp_type;

    typedef struct packed {
        logic on;
        logic [3:0] route;
    } civsr_amp_type;

    typedef struct packed {
        logic [6:0] code;
        logic mute;
        logic signed [7:0] gain_db;
    } civsr_spk_type;
endpackage : civsr_pkg
`default_nettype wire

// ### rtl/civsr_regs.sv
`default_nettype none
// Summary of operation
// - left amp on by bit4 or path enable
// - bits3..0 route left pins, pin1 resets 1
// - right amp on by bit4 or path enable
// - bits3..0 route right pins, pin1 resets 1
// - commit bit arms both gains, each applied once its zero-cross gating allows
// - left bit7 enables zero-cross gating
// - right bit7 enables zero-cross gating
// - codes up to 0x2f mute channel
// - low band -68 dB, then 1 dB steps
// - both gains reset to zero code
// - bit3 shows headphone thermal fault
// - bit2 shows headphone thermal warning
// - bit1 shows speaker thermal fault
// - bit0 shows speaker thermal warning
// - thermal flags read-only, writes ignored
// - bits14..12 select bias current limit
// - bits11..10 select bias short limit
// - bit9 enables bias current/short sensing
// - bit7 reports bias current over limit
// - bit6 reports bias short over limit
// - bit2 enables headphone sensor, reset 1
// - bit1 enables speaker sensor, reset 1
module civsr_regs (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // apb slave
    input wire civsr_pkg::civsr_apb_req_type apb_i,
    output civsr_pkg::civsr_apb_rsp_type apb_o,
    // input paths, same clock
    input wire logic left_input_path_on_i,
    input wire logic right_input_path_on_i,
    // zero crossing strobes, same clock
    input wire logic left_zero_cross_i,
    input wire logic right_zero_cross_i,
    // analogue status, asynchronous
    input wire logic hp_over_temp_fault_i,
    input wire logic hp_over_temp_warning_i,
    input wire logic spk_over_temp_fault_i,
    input wire logic spk_over_temp_warning_i,
    input wire logic bias_current_over_i,
    input wire logic bias_short_i,
    // input amp control
    output civsr_pkg::civsr_amp_type left_amp_o,
    output civsr_pkg::civsr_amp_type right_amp_o,
    // applied speaker gains
    output civsr_pkg::civsr_spk_type left_spk_o,
    output civsr_pkg::civsr_spk_type right_spk_o,
    // mic bias and sensors
    output logic [2:0] bias_current_limit_sel_o,
    output logic [1:0] bias_short_limit_sel_o,
    output logic bias_sense_on_o,
    output logic hp_thermal_sensor_on_o,
    output logic spk_thermal_sensor_on_o,
    output logic mic_supply_level_o
);
    import civsr_pkg::*;

    logic [4:0] left_ctrl_r;
    logic [4:0] right_ctrl_r;
    logic left_amp_on_r;
    logic right_amp_on_r;
    logic left_spk_zero_cross_on_r;
    logic right_spk_zero_cross_on_r;
    logic [6:0] left_shadow_r;
    logic [6:0] right_shadow_r;
    logic [6:0] left_spk_gain_r;
    logic [6:0] right_spk_gain_r;
    logic left_pend_r;
    logic right_pend_r;
    logic [15:0] mic_ctrl_r;
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    logic setup;
    logic wr_acc;
    logic [7:0] idx;
    logic mapped;
    logic commit_wr;
    logic left_apply;
    logic right_apply;
    logic [3:0] thermal_flags;
    logic bias_current_over_flag;
    logic bias_short_flag;
    logic [31:0] rd_val;

    // bus decode
    assign setup = apb_i.psel && !apb_i.penable;
    assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
    assign idx = apb_i.paddr[ADDR_W-1:2];
    always_comb begin
        unique case (idx)
            IDX_LEFT_INPUT_AMP_ROUTE, IDX_RIGHT_INPUT_AMP_ROUTE,
            IDX_LEFT_SPEAKER_VOLUME, IDX_RIGHT_SPEAKER_VOLUME,
            IDX_THERMAL_FLAGS, IDX_MIC_BIAS_CTRL: begin
                mapped = (apb_i.paddr[1:0] == 2'h0);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // input amp control registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            left_ctrl_r <= {1'b0, ROUTE_RST};
            right_ctrl_r <= {1'b0, ROUTE_RST};
        end else if (wr_acc && mapped) begin
            if (idx == IDX_LEFT_INPUT_AMP_ROUTE) begin
                left_ctrl_r <= apb_i.pwdata[4:0];
            end
            if (idx == IDX_RIGHT_INPUT_AMP_ROUTE) begin
                right_ctrl_r <= apb_i.pwdata[4:0];
            end
        end
    end

    // amp enable follows bit or path enable
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            left_amp_on_r <= 1'b0;
            right_amp_on_r <= 1'b0;
        end else begin
            left_amp_on_r <= left_ctrl_r[AMP_ON_BIT]
                || left_input_path_on_i;
            right_amp_on_r <= right_ctrl_r[AMP_ON_BIT]
                || right_input_path_on_i;
        end
    end

    // speaker shadows and zero-cross enables
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            left_shadow_r <= GAIN_RST;
            right_shadow_r <= GAIN_RST;
            left_spk_zero_cross_on_r <= 1'b0;
            right_spk_zero_cross_on_r <= 1'b0;
        end else if (wr_acc && mapped) begin
            if (idx == IDX_LEFT_SPEAKER_VOLUME) begin
                left_shadow_r <= apb_i.pwdata[6:0];
                left_spk_zero_cross_on_r <= apb_i.pwdata[ZC_BIT];
            end
            if (idx == IDX_RIGHT_SPEAKER_VOLUME) begin
                right_shadow_r <= apb_i.pwdata[6:0];
                right_spk_zero_cross_on_r <= apb_i.pwdata[ZC_BIT];
            end
        end
    end

    // commit from either volume register
    assign commit_wr = wr_acc && mapped && apb_i.pwdata[COMMIT_BIT]
        && (idx == IDX_LEFT_SPEAKER_VOLUME
        || idx == IDX_RIGHT_SPEAKER_VOLUME);
    assign left_apply = left_pend_r
        && (!left_spk_zero_cross_on_r || left_zero_cross_i);
    assign right_apply = right_pend_r
        && (!right_spk_zero_cross_on_r || right_zero_cross_i);

    // pending commit per channel, new commit wins over apply
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            left_pend_r <= 1'b0;
            right_pend_r <= 1'b0;
        end else begin
            left_pend_r <= commit_wr || (left_pend_r && !left_apply);
            right_pend_r <= commit_wr || (right_pend_r && !right_apply);
        end
    end

    // applied gains
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            left_spk_gain_r <= GAIN_RST;
            right_spk_gain_r <= GAIN_RST;
        end else begin
            if (left_apply) begin
                left_spk_gain_r <= left_shadow_r;
            end
            if (right_apply) begin
                right_spk_gain_r <= right_shadow_r;
            end
        end
    end

    // code to mute and dB
    function automatic civsr_spk_type gain_map(input logic [6:0] code);
        civsr_spk_type s;
        s.code = code;
        s.mute = (code <= GAIN_MUTE_TOP);
        if (code <= GAIN_MIN_TOP) begin
            s.gain_db = GAIN_MIN_DB;
        end else begin
            s.gain_db = 8'({1'b0, code}) - 8'({1'b0, GAIN_ZERO_DB});
        end
        return s;
    endfunction : gain_map

    // mic bias and sensor control
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mic_ctrl_r <= 16'h0000;
            mic_ctrl_r[RSVD_HI_BIT] <= 1'b1;
            mic_ctrl_r[RSVD_LO_BIT] <= 1'b1;
            mic_ctrl_r[HP_SENSOR_BIT] <= 1'b1;
            mic_ctrl_r[SPK_SENSOR_BIT] <= 1'b1;
            mic_ctrl_r[MIC_LVL_BIT] <= 1'b1;
        end else if (wr_acc && mapped && idx == IDX_MIC_BIAS_CTRL) begin
            mic_ctrl_r <= apb_i.pwdata[15:0];
            mic_ctrl_r[CUR_FLAG_BIT] <= 1'b0;
            mic_ctrl_r[SHORT_FLAG_BIT] <= 1'b0;
        end
    end

    // two-stage sync of analogue status
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sync1_r <= 6'h00;
            sync2_r <= 6'h00;
        end else begin
            sync1_r <= {bias_short_i, bias_current_over_i,
                hp_over_temp_fault_i, hp_over_temp_warning_i,
                spk_over_temp_fault_i, spk_over_temp_warning_i};
            sync2_r <= sync1_r;
        end
    end

    // status views
    assign thermal_flags = sync2_r[3:0];
    assign bias_current_over_flag = sync2_r[4]
        && mic_ctrl_r[SENSE_ON_BIT];
    assign bias_short_flag = sync2_r[5]
        && mic_ctrl_r[SENSE_ON_BIT];

    // read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (idx)
            IDX_LEFT_INPUT_AMP_ROUTE: begin
                rd_val[4:0] = left_ctrl_r;
            end
            IDX_RIGHT_INPUT_AMP_ROUTE: begin
                rd_val[4:0] = right_ctrl_r;
            end
            IDX_LEFT_SPEAKER_VOLUME: begin
                rd_val[7:0] = {left_spk_zero_cross_on_r, left_shadow_r};
            end
            IDX_RIGHT_SPEAKER_VOLUME: begin
                rd_val[7:0] = {right_spk_zero_cross_on_r, right_shadow_r};
            end
            IDX_THERMAL_FLAGS: begin
                rd_val[3:0] = thermal_flags;
            end
            IDX_MIC_BIAS_CTRL: begin
                rd_val[15:0] = mic_ctrl_r;
                rd_val[CUR_FLAG_BIT] = bias_current_over_flag;
                rd_val[SHORT_FLAG_BIT] = bias_short_flag;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // read data and error caught in setup phase
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            prdata_r <= mapped ? rd_val : 32'h0000_0000;
            pslverr_r <= !mapped;
        end
    end

    // outputs
    assign apb_o.pready = 1'b1;
    assign apb_o.pslverr = pslverr_r && apb_i.psel && apb_i.penable;
    assign apb_o.prdata = prdata_r;
    assign left_amp_o.on = left_amp_on_r;
    assign left_amp_o.route = left_ctrl_r[3:0];
    assign right_amp_o.on = right_amp_on_r;
    assign right_amp_o.route = right_ctrl_r[3:0];
    assign left_spk_o = gain_map(left_spk_gain_r);
    assign right_spk_o = gain_map(right_spk_gain_r);
    assign bias_current_limit_sel_o = mic_ctrl_r[CUR_LIM_LSB +: 3];
    assign bias_short_limit_sel_o = mic_ctrl_r[SHORT_LIM_LSB +: 2];
    assign bias_sense_on_o = mic_ctrl_r[SENSE_ON_BIT];
    assign hp_thermal_sensor_on_o = mic_ctrl_r[HP_SENSOR_BIT];
    assign spk_thermal_sensor_on_o = mic_ctrl_r[SPK_SENSOR_BIT];
    assign mic_supply_level_o = mic_ctrl_r[MIC_LVL_BIT];

    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    AST_LEFT_AMP_ON: assert property (
        left_amp_o.on == $past(left_ctrl_r[AMP_ON_BIT]
            || left_input_path_on_i))
        else $error("left amp enable wrong");
    AST_RIGHT_AMP_ON: assert property (
        right_input_path_on_i |=> right_amp_o.on)
        else $error("right amp not on with path");
    AST_ROUTE_RESET: assert property (
        $rose(rst_n_i) |-> left_amp_o.route == ROUTE_RST
            && right_amp_o.route == ROUTE_RST)
        else $error("route reset value wrong");
    AST_COMMIT_BOTH: assert property (
        (commit_wr && !apb_i.pwdata[ZC_BIT] && !left_spk_zero_cross_on_r
            && !right_spk_zero_cross_on_r && !left_pend_r) ##1
        (!left_spk_zero_cross_on_r && !right_spk_zero_cross_on_r)
        |=> left_spk_gain_r == $past(left_shadow_r)
            && right_spk_gain_r == $past(right_shadow_r))
        else $error("commit did not apply both gains");
    AST_MUTE_BAND: assert property (
        left_spk_o.mute == (left_spk_gain_r < 7'h30))
        else $error("mute band wrong");
    AST_GAIN_DB: assert property (
        left_spk_gain_r == GAIN_ZERO_DB |-> left_spk_o.gain_db == 8'sd0)
        else $error("0 dB code maps wrong");
    AST_HOLD_SHADOW: assert property (
        !left_pend_r |=> $stable(left_spk_gain_r))
        else $error("gain changed without commit");
    AST_ZC_WAIT: assert property (
        left_pend_r && left_spk_zero_cross_on_r && !left_zero_cross_i
        |=> $stable(left_spk_gain_r) && left_pend_r)
        else $error("gain changed before zero crossing");
    AST_THERMAL_RO: assert property (
        setup && mapped && idx == IDX_THERMAL_FLAGS
        |=> apb_o.prdata == {28'h0, $past(thermal_flags)})
        else $error("thermal read not from status");
    AST_BIAS_GATE: assert property (
        !bias_sense_on_o |-> !bias_current_over_flag && !bias_short_flag)
        else $error("bias flags set while sensing off");
    AST_SENSOR_RESET: assert property (
        $rose(rst_n_i) |-> hp_thermal_sensor_on_o && spk_thermal_sensor_on_o)
        else $error("sensor enable reset wrong");
    AST_RIGHT_ZC_WAIT: assert property (
        right_pend_r && right_spk_zero_cross_on_r && !right_zero_cross_i
        |=> $stable(right_spk_gain_r) && right_pend_r)
        else $error("right gain changed before zero crossing");
    AST_BIAS_READ: assert property (
        setup && mapped && idx == IDX_MIC_BIAS_CTRL
        |=> apb_o.prdata[7:6] == $past({sync2_r[4], sync2_r[5]}
            & {2{mic_ctrl_r[SENSE_ON_BIT]}}))
        else $error("bias status read wrong");
    AST_COMMIT_ARMS: assert property (
        commit_wr |=> left_pend_r && right_pend_r)
        else $error("commit did not arm both channels");
    AST_MIC_RESET: assert property (
        $rose(rst_n_i) |-> bias_current_limit_sel_o == CUR_LIM_RST
            && bias_short_limit_sel_o == SHORT_LIM_RST && !bias_sense_on_o)
        else $error("mic bias reset value wrong");
    AST_GAIN_RESET: assert property (
        $rose(rst_n_i) |-> left_spk_o.mute && right_spk_o.mute)
        else $error("speaker gain reset not muted");

    COV_COMMIT: cover property (commit_wr ##1 left_apply);
    COV_RIGHT_ZC: cover property (
        right_pend_r && right_spk_zero_cross_on_r ##1 right_apply);
    COV_ZC_WAIT: cover property (
        left_pend_r && left_spk_zero_cross_on_r ##3 left_apply);
    COV_UNMAPPED: cover property (apb_o.pslverr);
    COV_BIAS_SHORT: cover property (bias_short_flag);
endmodule : civsr_regs
`default_nettype wire

// ### test/test_codec_input_spk_vol_status_regs.sv
`default_nettype none
module test_codec_input_spk_vol_status_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import civsr_pkg::*;

    localparam logic [9:0] A_LA = {IDX_LEFT_INPUT_AMP_ROUTE, 2'b00};
    localparam logic [9:0] A_RA = {IDX_RIGHT_INPUT_AMP_ROUTE, 2'b00};
    localparam logic [9:0] A_LV = {IDX_LEFT_SPEAKER_VOLUME, 2'b00};
    localparam logic [9:0] A_RV = {IDX_RIGHT_SPEAKER_VOLUME, 2'b00};
    localparam logic [9:0] A_TH = {IDX_THERMAL_FLAGS, 2'b00};
    localparam logic [9:0] A_MB = {IDX_MIC_BIAS_CTRL, 2'b00};

    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    civsr_apb_req_type req = '0;
    civsr_apb_rsp_type rsp;
    logic [1:0] path_on = 2'b00;
    logic [1:0] zc = 2'b00;
    logic [3:0] therm = 4'h0;
    logic [1:0] bias = 2'b00;
    civsr_amp_type l_amp;
    civsr_amp_type r_amp;
    civsr_spk_type l_spk;
    civsr_spk_type r_spk;
    logic [2:0] cur_sel;
    logic [1:0] sh_sel;
    wire logic [3:0] ctl;
    logic [31:0] q;
    logic e;
    int n_fail = 0;
    int n_checks = 0;
    logic [6:0] codes [7] = '{7'h00, 7'h2f, 7'h30, 7'h35, 7'h36, 7'h79, 7'h7f};

    always #5 clk_sys_i = ~clk_sys_i;

    civsr_regs uut (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .apb_i(req),
        .apb_o(rsp),
        .left_input_path_on_i(path_on[1]),
        .right_input_path_on_i(path_on[0]),
        .left_zero_cross_i(zc[1]),
        .right_zero_cross_i(zc[0]),
        .hp_over_temp_fault_i(therm[3]),
        .hp_over_temp_warning_i(therm[2]),
        .spk_over_temp_fault_i(therm[1]),
        .spk_over_temp_warning_i(therm[0]),
        .bias_current_over_i(bias[1]),
        .bias_short_i(bias[0]),
        .left_amp_o(l_amp),
        .right_amp_o(r_amp),
        .left_spk_o(l_spk),
        .right_spk_o(r_spk),
        .bias_current_limit_sel_o(cur_sel),
        .bias_short_limit_sel_o(sh_sel),
        .bias_sense_on_o(ctl[3]),
        .hp_thermal_sensor_on_o(ctl[2]),
        .spk_thermal_sensor_on_o(ctl[1]),
        .mic_supply_level_o(ctl[0])
    );

    // expected applied gain word: code, mute, gain in dB
    function automatic logic [15:0] se(input logic [6:0] c);
        logic [7:0] g;
        g = (c <= 7'h35) ? 8'hbc : ({1'b0, c} - 8'd121);
        return {c, (c <= 7'h2f), g};
    endfunction : se

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask : cyc

    // one apb transfer; response sampled at the edge ending access
    task automatic apb(input logic w, input logic [9:0] a,
            input logic [31:0] d, output logic [31:0] rq, output logic re);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 100);
        if (n >= 100) n_fail++;
        rq = rsp.prdata;
        re = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [31:0] x,
            input logic xe);
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rd

    task automatic finish_test();
        $display("checks=%0d failures=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_fail++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // reset values
        rd(A_LA, 32'h8, 1'b0);
        rd(A_RA, 32'h8, 1'b0);
        rd(A_LV, 32'h0, 1'b0);
        rd(A_RV, 32'h0, 1'b0);
        rd(A_TH, 32'h0, 1'b0);
        rd(A_MB, 32'h8027, 1'b0);
        chk({l_spk, r_spk}, {se(7'h00), se(7'h00)});
        chk({22'h0, l_amp, r_amp}, {22'h0, 10'h108});
        // amp enables, routes and path override
        wr(A_LA, 32'h1f);
        wr(A_RA, 32'h15);
        cyc(2);
        rd(A_LA, 32'h1f, 1'b0);
        rd(A_RA, 32'h15, 1'b0);
        chk({22'h0, l_amp, r_amp}, {22'h0, 5'h1f, 5'h15});
        wr(A_LA, 32'h00);
        wr(A_RA, 32'h0a);
        path_on <= 2'b10;
        cyc(3);
        chk({22'h0, l_amp, r_amp}, {22'h0, 5'h10, 5'h0a});
        path_on <= 2'b01;
        cyc(3);
        chk({22'h0, l_amp, r_amp}, {22'h0, 5'h00, 5'h1a});
        path_on <= 2'b00;
        // shadow then joint commit
        wr(A_LV, 32'h079);
        wr(A_RV, 32'h030);
        cyc(3);
        chk({l_spk, r_spk}, {se(7'h00), se(7'h00)});
        wr(A_LV, 32'h179);
        cyc(2);
        chk({l_spk, r_spk}, {se(7'h79), se(7'h30)});
        rd(A_LV, 32'h079, 1'b0);
        foreach (codes[k]) begin
            wr(A_RV, 32'h100 | {25'h0, codes[k]});
            cyc(2);
            chk({16'h0, r_spk}, {16'h0, se(codes[k])});
        end
        // zero-cross gating, left then right
        wr(A_LV, 32'h0d0);
        wr(A_RV, 32'h140);
        cyc(3);
        chk({l_spk, r_spk}, {se(7'h79), se(7'h40)});
        zc <= 2'b10;
        cyc(1);
        zc <= 2'b00;
        cyc(1);
        chk({16'h0, l_spk}, {16'h0, se(7'h50)});
        rd(A_LV, 32'h0d0, 1'b0);
        wr(A_RV, 32'h1c5);
        cyc(3);
        chk({16'h0, r_spk}, {16'h0, se(7'h40)});
        zc <= 2'b01;
        cyc(1);
        zc <= 2'b00;
        cyc(1);
        chk({16'h0, r_spk}, {16'h0, se(7'h45)});
        // thermal flags, one at a time, then write attempt
        for (int i = 0; i < 4; i++) begin
            therm <= 4'h1 << i;
            cyc(3);
            rd(A_TH, 32'h1 << i, 1'b0);
        end
        therm <= 4'ha;
        cyc(3);
        wr(A_TH, 32'hffff);
        rd(A_TH, 32'ha, 1'b0);
        // bias sensing and sensor enables
        bias <= 2'b11;
        cyc(3);
        rd(A_MB, 32'h8027, 1'b0);
        wr(A_MB, 32'hffff);
        cyc(3);
        rd(A_MB, 32'hffff, 1'b0);
        chk({23'h0, cur_sel, sh_sel, ctl}, 32'h1ff);
        bias <= 2'b10;
        wr(A_MB, 32'h9620);
        cyc(3);
        rd(A_MB, 32'h96a0, 1'b0);
        chk({23'h0, cur_sel, sh_sel, ctl}, 32'h058);
        wr(A_MB, 32'h8020);
        cyc(3);
        rd(A_MB, 32'h8020, 1'b0);
        // unmapped and misaligned
        rd(10'h100, 32'h0, 1'b1);
        rd(A_LA + 10'h1, 32'h0, 1'b1);
        finish_test();
    end
endmodule : test_codec_input_spk_vol_status_regs
`default_nettype wire
